/* File: rtl/tms_pkg.sv */
// Shared constants of the trigger macro sequencer
package tms_pkg;
	// ****************************************
	// Register map: word index, byte = 4*index
	// ****************************************
	localparam int TMS_NCFG = 9;
	localparam int TMS_IDX_CTRL = 0;
	localparam int TMS_IDX_P1 = 1;
	localparam int TMS_IDX_P2 = 2;
	localparam int TMS_IDX_P3 = 3;
	localparam int TMS_IDX_MASK = 4;
	localparam int TMS_IDX_COUNT = 5;
	localparam int TMS_IDX_DUR = 6;
	localparam int TMS_IDX_DUR2 = 7;
	localparam int TMS_IDX_SER = 8;
	localparam int TMS_IDX_CMD = 9;
	localparam int TMS_IDX_STAT = 10;
	localparam logic [31:0] TMS_CFG_RST = 32'h0000_0000;
	// ****************************************
	// Control word fields
	// ****************************************
	localparam int TMS_F_MODE = 0;
	localparam int TMS_F_ABSENT = 1;
	localparam int TMS_F_LT = 2;
	localparam int TMS_F_EDGE_LO = 4;
	localparam int TMS_F_EDGE_HI = 5;
	localparam int TMS_F_MAC_LO = 8;
	localparam int TMS_F_MAC_HI = 12;
	localparam int TMS_F_CH_LO = 16;
	// Command bits
	localparam int TMS_C_ARM = 0;
	localparam int TMS_C_STOP = 1;
	localparam int TMS_C_BREAK = 2;
	localparam int TMS_C_RESTORE = 3;
	// Status fields
	localparam int TMS_S_RUN = 0;
	localparam int TMS_S_TRIG = 1;
	localparam int TMS_S_EXP = 2;
	localparam int TMS_S_LV_LO = 8;
	localparam int TMS_S_CNT_LO = 16;
	// ****************************************
	// Macro codes
	// ****************************************
	localparam logic [4:0] TMS_M_USER = 5'h00;
	localparam logic [4:0] TMS_M_ANY_N = 5'h01;
	localparam logic [4:0] TMS_M_PAT_GE = 5'h02;
	localparam logic [4:0] TMS_M_PAT_LT = 5'h03;
	localparam logic [4:0] TMS_M_EDGE = 5'h04;
	localparam logic [4:0] TMS_M_EDGE_PAT = 5'h05;
	localparam logic [4:0] TMS_M_PAT_SOON = 5'h06;
	localparam logic [4:0] TMS_M_PAT_LATE = 5'h07;
	localparam logic [4:0] TMS_M_EDGE_CLOSE = 5'h08;
	localparam logic [4:0] TMS_M_EDGE_FAR = 5'h09;
	localparam logic [4:0] TMS_M_WIDTH = 5'h0a;
	localparam logic [4:0] TMS_M_DELAY = 5'h0b;
	localparam logic [4:0] TMS_M_EV_N = 5'h0c;
	localparam logic [4:0] TMS_M_EV_CONSEC = 5'h0d;
	localparam logic [4:0] TMS_M_B2B = 5'h0e;
	localparam logic [4:0] TMS_M_EV2_N_B3 = 5'h0f;
	localparam logic [4:0] TMS_M_FEW = 5'h10;
	localparam logic [4:0] TMS_M_MANY = 5'h11;
	localparam logic [4:0] TMS_M_SERIAL = 5'h12;
	localparam logic [4:0] TMS_M_SOON_T = 5'h13;
	localparam logic [4:0] TMS_M_LATE_T = 5'h14;
	// Internal level usage
	localparam logic [7:0] TMS_LV_ONE = 8'h01;
	localparam logic [7:0] TMS_LV_TWO = 8'h02;
	localparam logic [7:0] TMS_LV_THREE = 8'h03;
	localparam logic [7:0] TMS_LV_FOUR = 8'h04;
	localparam logic [7:0] TMS_LV_FIVE = 8'h05;
	// Durations count in clock periods of 100 ns
	localparam int TMS_CLK_NS = 100;
	localparam int TMS_DUR_UNIT_NS = 100;
	localparam int TMS_DUR_CYC = TMS_DUR_UNIT_NS / TMS_CLK_NS;
	typedef enum logic [1:0] {
		TMS_ST_IDLE = 2'b00,
		TMS_ST_FIRST = 2'b01,
		TMS_ST_SECOND = 2'b10,
		TMS_ST_DONE = 2'b11
	} tms_state_t;
endpackage

/* File: rtl/tms_sequencer.sv */
// Trigger macro sequencer with Avalon-MM register slave
// Overview of operation
// - User level takes one level; four when less-than duration used.
// - Break down copies macro into editable long-form levels.
// - Restore drops edits and reinstates original macro and branching.
// - Any-state fires when first sampled state is seen n times.
// - Pattern present or absent at least duration fires.
// - Pattern present or absent shorter than duration fires; four or five.
// - Edge macros fire on selected edge or its Nth occurrence.
// - Edge within pattern fires when edge and pattern share a sample.
// - Pattern within duration after edge fires; three or four levels.
// - Pattern absent throughout period after edge fires; two levels.
// - Second edge within period after first fires; three or four.
// - Second edge later than period after first fires; two levels.
// - Pattern width outside min and max fires; four or five levels.
// - Delay fires after time in timing, n user clocks in state.
// - Event count fires after n matches, consecutive or not.
// - Consecutive event fires after n matches in a row.
// - Back-to-back fires when pattern two follows one next state.
// - Count n pattern two after one; pattern three restarts, wins ties.
// - Too few states between pattern one and two fires.
// - Too many states, at least n, between one and two fires.
// - Serial pattern of n bits on one channel, n levels.
// - Pattern two sooner or not sooner than time after one fires.
`timescale 1ns/10ps
module tms_sequencer import tms_pkg::*; #(
	parameter int PW = 32,
	parameter int CW = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Avalon-MM slave
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Probes and user clock
	input wire logic [PW-1:0] probe_in,
	input wire logic user_clk_in,
	// Trigger
	output logic trig_out
);
	localparam int CHW = $clog2(PW);
	localparam logic [CW-1:0] CNT_ONE = CW'(1);
	localparam logic [CW-1:0] CNT_MAX = {CW{1'b1}};

	// ****************************************
	// Register slave
	// ****************************************
	logic [31:0] cfg_reg [TMS_NCFG];
	logic [31:0] sav_reg [TMS_NCFG];
	logic expanded_reg;
	logic [31:0] status_w;
	wire [3:0] widx = avs_address[5:2];
	wire wr_fire = avs_write & ~avs_waitrequest;
	wire wr_cfg = wr_fire & (widx < 4'(TMS_NCFG));
	wire wr_cmd = wr_fire & (widx == 4'(TMS_IDX_CMD)) & avs_byteenable[0];
	wire cmd_arm = wr_cmd & avs_writedata[TMS_C_ARM];
	wire cmd_stop = wr_cmd & avs_writedata[TMS_C_STOP];
	wire cmd_break = wr_cmd & avs_writedata[TMS_C_BREAK] & ~expanded_reg;
	wire cmd_rest = wr_cmd & avs_writedata[TMS_C_RESTORE] & expanded_reg;
	wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	wire [31:0] rd_word = (widx < 4'(TMS_NCFG)) ? cfg_reg[widx] :
		(widx == 4'(TMS_IDX_STAT)) ? status_w : TMS_CFG_RST;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= TMS_CFG_RST;
		end else if (avs_waitrequest) begin
			avs_waitrequest <= ~(avs_read | avs_write);
			avs_readdata <= rd_word;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	// Restore outranks any write in the same cycle
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < TMS_NCFG; i++) begin
				cfg_reg[i] <= TMS_CFG_RST;
			end
		end else if (cmd_rest) begin
			for (int i = 0; i < TMS_NCFG; i++) begin
				cfg_reg[i] <= sav_reg[i];
			end
		end else if (wr_cfg) begin
			cfg_reg[widx] <= (cfg_reg[widx] & ~be_mask) |
				(avs_writedata & be_mask);
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			expanded_reg <= 1'b0;
			for (int i = 0; i < TMS_NCFG; i++) begin
				sav_reg[i] <= TMS_CFG_RST;
			end
		end else if (cmd_break) begin
			expanded_reg <= 1'b1;
			for (int i = 0; i < TMS_NCFG; i++) begin
				sav_reg[i] <= cfg_reg[i];
			end
		end else if (cmd_rest) begin
			expanded_reg <= 1'b0;
		end
	end

	// ****************************************
	// Configuration decode
	// ****************************************
	wire [31:0] ctrl = cfg_reg[TMS_IDX_CTRL];
	wire mode_state = ctrl[TMS_F_MODE];
	wire absent = ctrl[TMS_F_ABSENT];
	wire lt_on = ctrl[TMS_F_LT];
	// Less-than duration exists only in timing mode
	wire lt_dur = lt_on & ~mode_state;
	wire [1:0] etype = ctrl[TMS_F_EDGE_HI:TMS_F_EDGE_LO];
	wire [4:0] macro = ctrl[TMS_F_MAC_HI:TMS_F_MAC_LO];
	wire [CHW-1:0] chan = ctrl[TMS_F_CH_LO +: CHW];
	wire [PW-1:0] mask = cfg_reg[TMS_IDX_MASK][PW-1:0];
	wire [CW-1:0] n_val = cfg_reg[TMS_IDX_COUNT][CW-1:0];
	wire [CW-1:0] dur_val = cfg_reg[TMS_IDX_DUR][CW-1:0];
	wire [CW-1:0] dur2_val = cfg_reg[TMS_IDX_DUR2][CW-1:0];
	wire [5:0] n_bits = cfg_reg[TMS_IDX_COUNT][5:0];
	wire [31:0] ser_pat = cfg_reg[TMS_IDX_SER];
	wire [31:0] ser_mask = n_bits[5] ? {32{1'b1}} :
		((32'h0000_0001 << n_bits[4:0]) - 32'h0000_0001);

	function automatic logic [7:0] tms_levels(input logic [4:0] mac,
			input logic lt, input logic ab, input logic [1:0] et,
			input logic [5:0] nb);
		logic [7:0] lv;
		lv = TMS_LV_ONE;
		case (mac)
			TMS_M_USER: lv = lt ? TMS_LV_FOUR : TMS_LV_ONE;
			TMS_M_PAT_LT, TMS_M_WIDTH: begin
				lv = ab ? TMS_LV_FIVE : TMS_LV_FOUR;
			end
			TMS_M_PAT_SOON, TMS_M_EDGE_CLOSE, TMS_M_FEW: begin
				lv = (&et) ? TMS_LV_FOUR : TMS_LV_THREE;
			end
			TMS_M_PAT_LATE, TMS_M_EDGE_FAR, TMS_M_B2B, TMS_M_EV2_N_B3,
			TMS_M_MANY, TMS_M_SOON_T, TMS_M_LATE_T: lv = TMS_LV_TWO;
			TMS_M_SERIAL: lv = {2'b00, nb};
			default: lv = TMS_LV_ONE;
		endcase
		return lv;
	endfunction

	wire [7:0] levels = tms_levels(macro, lt_dur, absent, etype, n_bits);

	// ****************************************
	// Probe sampling
	// ****************************************
	// Timing mode samples every clock; state mode on user clock rise
	logic [PW-1:0] probe_meta_reg, probe_sync_reg, last_reg;
	logic uclk_meta_reg, uclk_sync_reg, uclk_last_reg;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			probe_meta_reg <= '0;
			probe_sync_reg <= '0;
			uclk_meta_reg <= 1'b0;
			uclk_sync_reg <= 1'b0;
			uclk_last_reg <= 1'b0;
		end else begin
			probe_meta_reg <= probe_in;
			probe_sync_reg <= probe_meta_reg;
			uclk_meta_reg <= user_clk_in;
			uclk_sync_reg <= uclk_meta_reg;
			uclk_last_reg <= uclk_sync_reg;
		end
	end

	wire [PW-1:0] cur = probe_sync_reg;
	wire smp = mode_state ? (uclk_sync_reg & ~uclk_last_reg) : 1'b1;
	wire m1 = ((cur ^ cfg_reg[TMS_IDX_P1][PW-1:0]) & mask) == '0;
	wire m2 = ((cur ^ cfg_reg[TMS_IDX_P2][PW-1:0]) & mask) == '0;
	wire m3 = ((cur ^ cfg_reg[TMS_IDX_P3][PW-1:0]) & mask) == '0;
	wire pres = m1 ^ absent;
	wire cb = cur[chan];
	wire lb = last_reg[chan];
	wire edge_hit = (etype[0] & cb & ~lb) | (etype[1] & ~cb & lb);

	// ****************************************
	// Sequencer engine
	// ****************************************
	tms_state_t stage_reg, stage_next;
	logic [CW-1:0] cnt_reg, cnt_next, tmr_reg, tmr_next;
	logic [PW-1:0] first_reg, first_next;
	logic [31:0] ser_reg;
	logic trig_seen_reg, hit;
	wire running = (stage_reg == TMS_ST_FIRST) | (stage_reg == TMS_ST_SECOND);
	wire [CW-1:0] cnt_inc = (cnt_reg == CNT_MAX) ? cnt_reg : cnt_reg + CNT_ONE;
	wire [CW-1:0] tmr_inc = (tmr_reg == CNT_MAX) ? tmr_reg : tmr_reg + CNT_ONE;
	wire [31:0] ser_next = {ser_reg[30:0], cb};
	wire first_st = (stage_reg == TMS_ST_FIRST);

	always_comb begin
		stage_next = stage_reg;
		cnt_next = cnt_reg;
		tmr_next = tmr_inc;
		first_next = first_reg;
		hit = 1'b0;
		if (smp && running) begin
			case (macro)
				TMS_M_ANY_N: begin
					if (first_st) begin
						first_next = cur;
						cnt_next = CNT_ONE;
						stage_next = TMS_ST_SECOND;
						hit = (n_val <= CNT_ONE);
					end else if (cur == first_reg) begin
						cnt_next = cnt_inc;
						hit = (cnt_inc >= n_val);
					end
				end
				TMS_M_PAT_GE: begin
					cnt_next = pres ? cnt_inc : '0;
					hit = pres & (cnt_inc >= dur_val);
				end
				TMS_M_USER, TMS_M_PAT_LT, TMS_M_WIDTH: begin
					cnt_next = pres ? cnt_inc : '0;
					if (macro == TMS_M_USER && !lt_dur) begin
						hit = m1;
					end else if (!pres && cnt_reg != '0) begin
						hit = (cnt_reg < dur_val) |
							((macro == TMS_M_WIDTH) & (cnt_reg > dur2_val));
					end
				end
				TMS_M_EDGE: begin
					if (edge_hit) begin
						cnt_next = cnt_inc;
						hit = (cnt_inc >= n_val);
					end
				end
				TMS_M_EDGE_PAT: hit = edge_hit & m1;
				TMS_M_PAT_SOON, TMS_M_PAT_LATE,
				TMS_M_EDGE_CLOSE, TMS_M_EDGE_FAR: begin
					if (first_st) begin
						if (edge_hit) begin
							stage_next = TMS_ST_SECOND;
							tmr_next = '0;
						end
					end else if (macro == TMS_M_PAT_SOON) begin
						hit = m1 & (tmr_inc <= dur_val);
						if (!hit && tmr_inc > dur_val) stage_next = TMS_ST_FIRST;
					end else if (macro == TMS_M_PAT_LATE) begin
						if (m1) stage_next = TMS_ST_FIRST;
						else hit = (tmr_inc >= dur_val);
					end else if (edge_hit) begin
						// A second edge that does not fire becomes the next first edge
						hit = (macro == TMS_M_EDGE_CLOSE) ?
							(tmr_inc <= dur_val) : (tmr_inc > dur_val);
						tmr_next = '0;
					end
				end
				TMS_M_DELAY: begin
					cnt_next = cnt_inc;
					hit = cnt_inc >= (mode_state ? n_val : dur_val);
				end
				TMS_M_EV_N: begin
					if (m1) begin
						cnt_next = cnt_inc;
						hit = (cnt_inc >= n_val);
					end
				end
				TMS_M_EV_CONSEC: begin
					cnt_next = m1 ? cnt_inc : '0;
					hit = m1 & (cnt_inc >= n_val);
				end
				TMS_M_B2B, TMS_M_EV2_N_B3, TMS_M_FEW, TMS_M_MANY,
				TMS_M_SOON_T, TMS_M_LATE_T: begin
					if (first_st) begin
						if (m1) begin
							stage_next = TMS_ST_SECOND;
							cnt_next = '0;
							tmr_next = '0;
						end
					end else case (macro)
						TMS_M_B2B: begin
							hit = m2;
							if (!m2 && !m1) stage_next = TMS_ST_FIRST;
						end
						TMS_M_EV2_N_B3: begin
							if (m3) begin
								stage_next = TMS_ST_FIRST;
								cnt_next = '0;
							end else if (m2) begin
								cnt_next = cnt_inc;
								hit = (cnt_inc >= n_val);
							end
						end
						TMS_M_FEW, TMS_M_MANY: begin
							if (m2) begin
								hit = (macro == TMS_M_FEW) ?
									(cnt_reg < n_val) : (cnt_reg >= n_val);
								stage_next = TMS_ST_FIRST;
							end else begin
								cnt_next = cnt_inc;
							end
						end
						default: begin
							if (m2) begin
								hit = (macro == TMS_M_SOON_T) ?
									(tmr_inc < dur_val) : (tmr_inc >= dur_val);
								stage_next = TMS_ST_FIRST;
							end
						end
					endcase
				end
				TMS_M_SERIAL: begin
					cnt_next = cnt_inc;
					hit = (((ser_next ^ ser_pat) & ser_mask) == '0) &
						({{(32-CW){1'b0}}, cnt_inc} >= {26'h000_0000, n_bits});
				end
				default: hit = 1'b0;
			endcase
			if (hit) stage_next = TMS_ST_DONE;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			stage_reg <= TMS_ST_IDLE;
			cnt_reg <= '0;
			tmr_reg <= '0;
			first_reg <= '0;
		end else if (cmd_arm && !cmd_rest) begin
			stage_reg <= TMS_ST_FIRST;
			cnt_reg <= '0;
			tmr_reg <= '0;
		end else if (cmd_stop || cmd_rest) begin
			stage_reg <= TMS_ST_IDLE;
		end else begin
			stage_reg <= stage_next;
			cnt_reg <= cnt_next;
			tmr_reg <= tmr_next;
			first_reg <= first_next;
		end
	end

	// Trigger seen: set beats clear by arm
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			trig_out <= 1'b0;
			trig_seen_reg <= 1'b0;
			ser_reg <= '0;
			last_reg <= '0;
		end else begin
			trig_out <= hit;
			trig_seen_reg <= hit | (trig_seen_reg & ~cmd_arm);
			if (smp) begin
				ser_reg <= ser_next;
				last_reg <= cur;
			end
		end
	end

	assign status_w = {cnt_reg, levels, 2'b00, stage_reg, 1'b0,
		expanded_reg, trig_seen_reg, running};

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb_clk @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire [31:0] sav_ctrl = sav_reg[TMS_IDX_CTRL];
	wire [CW-1:0] sav_dur = sav_reg[TMS_IDX_DUR][CW-1:0];

	AST_TRIG_ONE_CYCLE: assert property (trig_out |=> !trig_out)
		else $error("trigger pulse longer than one cycle");
	AST_TRIG_DONE: assert property (hit && !cmd_arm && !cmd_stop &&
		!cmd_rest |=> trig_out &&
		stage_reg == TMS_ST_DONE && trig_seen_reg)
		else $error("trigger without done state");
	AST_USER_LEVELS: assert property (macro == TMS_M_USER |->
		levels == (lt_dur ? TMS_LV_FOUR : TMS_LV_ONE))
		else $error("user level usage wrong");
	AST_BREAK: assert property (cmd_break |=> expanded_reg &&
		sav_ctrl == $past(ctrl) && sav_dur == $past(dur_val, 1))
		else $error("break down did not snapshot macro");
	AST_RESTORE: assert property (cmd_rest |=> !expanded_reg &&
		ctrl == $past(sav_ctrl) && stage_reg == TMS_ST_IDLE)
		else $error("restore did not reinstate macro");
	AST_CONSEC: assert property (hit && macro == TMS_M_EV_CONSEC |->
		m1 && cnt_inc >= n_val)
		else $error("consecutive trigger without run");
	AST_B2B: assert property (hit && macro == TMS_M_B2B |->
		m2 && stage_reg == TMS_ST_SECOND)
		else $error("back to back trigger out of order");
	AST_P3_WINS: assert property (smp && macro == TMS_M_EV2_N_B3 && m3 &&
		stage_reg == TMS_ST_SECOND && !cmd_arm && !cmd_stop && !cmd_rest
		|-> !hit ##1 stage_reg == TMS_ST_FIRST && cnt_reg == '0)
		else $error("pattern three did not restart");
	AST_EDGE_PAT: assert property (hit && macro == TMS_M_EDGE_PAT |->
		edge_hit && m1)
		else $error("edge trigger outside pattern");
	AST_SERIAL_LV: assert property (macro == TMS_M_SERIAL |->
		levels == {2'b00, n_bits})
		else $error("serial level usage wrong");
	CV_B2B: cover property (trig_out && macro == TMS_M_B2B);
	CV_P3: cover property (hit && macro == TMS_M_EV2_N_B3);
	CV_RESTORE: cover property (cmd_break ##[1:50] cmd_rest);
	CV_STATE_DELAY: cover property (hit && macro == TMS_M_DELAY && mode_state);
endmodule

/* File: verif/tms_probe_model.sv */
// Probe and user clock model of the system under test
`timescale 1ns/10ps
module tms_probe_model (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Bench control
	input wire logic state_en,
	input wire logic send,
	input wire logic [31:0] vec,
	output logic ready,
	// Probe side
	output logic [31:0] probe_in,
	output logic user_clk_in
);
	logic [3:0] cnt_reg;
	// User clock stands low between samples
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_reg <= 4'h0;
			probe_in <= 32'h0000_0000;
			user_clk_in <= 1'b0;
			ready <= 1'b0;
		end else if (!state_en) begin
			probe_in <= vec;
			ready <= 1'b0;
		end else begin
			ready <= (cnt_reg == 4'hc);
			user_clk_in <= (cnt_reg >= 4'h3) && (cnt_reg < 4'h6);
			if (cnt_reg != 4'h0)
				cnt_reg <= (cnt_reg == 4'hc) ? 4'h0 : cnt_reg + 4'h1;
			else if (send) begin
				cnt_reg <= 4'h1;
				probe_in <= vec;
			end
			// Hold time over: show the inverse, never a stale match
			if (cnt_reg == 4'h8)
				probe_in <= ~probe_in;
		end
	end
endmodule

/* File: verif/tb_top.sv */
// Self-checking bench of the trigger macro sequencer
`timescale 1ns/10ps
module tb_top import tms_pkg::*;;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [31:0] probe_in;
	logic user_clk_in;
	logic trig_out;
	logic state_en = 1'b0;
	logic send = 1'b0;
	logic [31:0] vec = 32'h0000_0000;
	logic ready;
	logic trig_q = 1'b0;
	logic prev1, st1, hit;
	logic [31:0] pat [3] = '{32'h0000_00a5, 32'h0000_003c, 32'h0000_00c6};
	int pre [8] = '{0, 0, 3, 0, 1, 0, 0, 0};
	int errors = 0;
	int checks_done = 0;
	int trig_cnt = 0;
	int trig_hi = 0;
	int t0, cnt, run;

	always #50 clk = ~clk;

	tms_sequencer i_dut (.clk(clk), .sys_rst(sys_rst),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .probe_in(probe_in),
		.user_clk_in(user_clk_in), .trig_out(trig_out));
	tms_probe_model i_probe (.clk(clk), .sys_rst(sys_rst),
		.state_en(state_en), .send(send), .vec(vec), .ready(ready),
		.probe_in(probe_in), .user_clk_in(user_clk_in));

	// A pulse longer than one cycle shows as more high cycles than rises
	always @(posedge clk) begin
		trig_q <= trig_out;
		if (trig_out === 1'b1)
			trig_hi++;
		if (trig_out === 1'b1 && trig_q !== 1'b1)
			trig_cnt++;
	end

	// ********
	// Tasks
	// ********
	task automatic finish_test();
		if (errors == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("unexpected %s: expected %h seen %h", name, exp, got);
			errors++;
		end
	endtask
	task automatic bus(input logic w, input int idx, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		avs_address <= 6'(idx * 4);
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		avs_byteenable <= 4'hf;
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wr(input int idx, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, idx, d, q);
	endtask
	task automatic rd(input int idx, output logic [31:0] q);
		bus(1'b0, idx, 32'h0000_0000, q);
	endtask
	task automatic arm(input logic [31:0] c);
		wr(TMS_IDX_CMD, 32'h0000_0002);
		wr(TMS_IDX_CTRL, c);
		wr(TMS_IDX_CMD, 32'h0000_0001);
		t0 = trig_cnt;
	endtask
	task automatic hold(input logic [31:0] v, input int c);
		@(posedge clk);
		vec <= v;
		repeat (c) @(posedge clk);
	endtask
	task automatic sample(input logic [31:0] v);
		@(posedge clk);
		send <= 1'b1;
		vec <= v;
		@(posedge clk);
		send <= 1'b0;
		do begin
			@(posedge clk);
		end while (ready !== 1'b1);
		repeat (2) @(posedge clk);
	endtask

	// ********
	// Reference
	// ********
	function automatic logic [31:0] cw(input logic [4:0] m, input logic st,
		input logic ab, input logic lt, input logic [1:0] et);
		return 32'(st) | (32'(ab) << TMS_F_ABSENT) | (32'(lt) << TMS_F_LT)
			| (32'(et) << TMS_F_EDGE_LO) | (32'(m) << TMS_F_MAC_LO);
	endfunction
	function automatic logic [7:0] exp_lv(input logic [4:0] m,
		input logic st, input logic lt, input logic ab, input logic [1:0] et,
		input logic [5:0] n);
		case (m)
			TMS_M_USER: return (lt && !st) ? 8'h04 : 8'h01;
			TMS_M_PAT_LT, TMS_M_WIDTH: return ab ? 8'h05 : 8'h04;
			TMS_M_PAT_SOON, TMS_M_EDGE_CLOSE, TMS_M_FEW:
				return (et == 2'b11) ? 8'h04 : 8'h03;
			TMS_M_PAT_LATE, TMS_M_EDGE_FAR, TMS_M_B2B, TMS_M_EV2_N_B3,
			TMS_M_MANY, TMS_M_SOON_T, TMS_M_LATE_T: return 8'h02;
			TMS_M_SERIAL: return {2'b00, n};
			default: return 8'h01;
		endcase
	endfunction
	// Pattern three is tested first, so it wins a tie with the nth match
	task automatic ref_step(input logic [4:0] m, input logic [31:0] v);
		logic m1, m2, m3;
		m1 = (v & 32'hff) == pat[0];
		m2 = (v & 32'hff) == pat[1];
		m3 = (v & 32'hff) == pat[2];
		if (m == TMS_M_EV_N)
			cnt += int'(m1);
		else if (m == TMS_M_EV_CONSEC)
			run = m1 ? run + 1 : 0;
		else if (m == TMS_M_B2B)
			hit |= prev1 && m2;
		else if (m3) begin
			st1 = 1'b0;
			cnt = 0;
		end else if (st1 && m2)
			cnt++;
		else if (m1)
			st1 = 1'b1;
		hit |= (cnt >= 3) || (run >= 3);
		prev1 = m1;
	endtask

	initial begin
		repeat (30000) @(posedge clk);
		errors++;
		finish_test();
	end

	// ********
	// Tests
	// ********
	initial begin
		logic [31:0] q, c0, v;
		logic st, ab, lt;
		logic [1:0] et;
		logic [4:0] m;
		logic [5:0] n;
		int edges, s;
		void'($urandom(32'haa54));
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		rd(TMS_IDX_STAT, q);
		chk("status after reset", 32'h0000_0100, q);
		wr(13, 32'hffff_ffff);
		rd(13, q);
		chk("unmapped word", 32'h0000_0000, q);
		for (int i = 0; i <= 20; i++) begin
			m = 5'(i);
			st = (i >= 12) || ((i == 0 || i == 1 || i == 11) &&
				$urandom_range(1) == 1);
			{ab, lt} = 2'($urandom_range(3));
			et = 2'($urandom_range(3, 1));
			n = 6'($urandom_range(32, 1));
			wr(TMS_IDX_COUNT, 32'(n));
			wr(TMS_IDX_CTRL, cw(m, st, ab, lt, et));
			rd(TMS_IDX_STAT, q);
			chk("levels", 32'(exp_lv(m, st, lt, ab, et, n)), 32'(q[15:8]));
		end
		// State mode: three patterns on the low byte; the last run sets pattern three equal to pattern two
		state_en <= 1'b1;
		for (int i = 0; i < 3; i++)
			wr(TMS_IDX_P1 + i, pat[i]);
		wr(TMS_IDX_MASK, 32'h0000_00ff);
		wr(TMS_IDX_COUNT, 32'h0000_0003);
		for (int r = 0; r < 5; r++) begin
			m = (r == 4) ? TMS_M_EV2_N_B3 : TMS_M_EV_N + 5'(r);
			if (r == 4) begin
				pat[2] = pat[1];
				wr(TMS_IDX_P3, pat[1]);
			end
			arm(cw(m, 1'b1, 1'b0, 1'b0, 2'b00));
			{cnt, run, prev1, st1, hit} = '0;
			for (int k = 0; k < 32; k++) begin
				s = (k < 8) ? pre[k] : int'($urandom_range(3));
				v = ($urandom() & 32'hffff_ff00) | (s < 3 ? pat[s] : 32'h11);
				sample(v);
				ref_step(m, v);
				chk("state trigger", 32'(hit), 32'(trig_cnt - t0));
			end
		end
		state_en <= 1'b0;
		// Timing mode: third edge of each kind on bit 0
		wr(TMS_IDX_MASK, 32'h0000_0001);
		for (int e = 1; e <= 3; e++) begin
			hold(32'h0000_0000, 6);
			arm(cw(TMS_M_EDGE, 1'b0, 1'b0, 1'b0, 2'(e)));
			edges = 0;
			for (int k = 1; k <= 6; k++) begin
				hold(32'(k % 2), 8);
				edges += int'(e == 3 || (e == 1) == (k % 2 == 1));
				chk("edge trigger", 32'(edges >= 3), 32'(trig_cnt - t0));
			end
			rd(TMS_IDX_STAT, q);
			chk("stage and flag", 32'h0000_0007, {29'h0, q[5:4], q[1]});
		end
		wr(TMS_IDX_MASK, 32'h0000_00ff);
		wr(TMS_IDX_DUR, 32'h0000_0006);
		for (int a = 0; a < 2; a++) begin
			// With absent set, a non-matching value is what counts
			v = a ? 32'h0000_005a : pat[0];
			q = a ? pat[0] : 32'h0000_005a;
			hold(q, 12);
			arm(cw(TMS_M_PAT_GE, 1'b0, 1'(a), 1'b0, 2'b00));
			hold(v, 3);
			hold(q, 8);
			chk("short pattern", 32'h0, 32'(trig_cnt - t0));
			hold(v, 14);
			chk("long pattern", 32'h1, 32'(trig_cnt - t0));
		end
		wr(TMS_IDX_DUR, 32'h0000_0014);
		arm(cw(TMS_M_DELAY, 1'b0, 1'b0, 1'b0, 2'b00));
		hold(32'h0000_0000, 12);
		chk("early delay", 32'h0, 32'(trig_cnt - t0));
		hold(32'h0000_0000, 20);
		chk("delay", 32'h1, 32'(trig_cnt - t0));
		// Break down, edit, restore
		c0 = cw(TMS_M_EDGE_CLOSE, 1'b0, 1'b0, 1'b0, 2'b11);
		wr(TMS_IDX_CTRL, c0);
		wr(TMS_IDX_P1, 32'h1234_5678);
		wr(TMS_IDX_CMD, 32'h0000_0004);
		rd(TMS_IDX_STAT, q);
		chk("expanded flag", 32'h1, 32'(q[2]));
		wr(TMS_IDX_CTRL, 32'h0000_0000);
		wr(TMS_IDX_P1, 32'h0000_0f0f);
		rd(TMS_IDX_P1, q);
		chk("edited level", 32'h0000_0f0f, q);
		wr(TMS_IDX_CMD, 32'h0000_0008);
		rd(TMS_IDX_CTRL, q);
		chk("restored control", c0, q);
		rd(TMS_IDX_P1, q);
		chk("restored pattern", 32'h1234_5678, q);
		rd(TMS_IDX_STAT, q);
		chk("restored status", 32'h0000_0400, q & 32'h0000_ff34);
		chk("pulse length", 32'(trig_cnt), 32'(trig_hi));
		finish_test();
	end
endmodule
